// file: verilog/uotg_otg_ctrl.sv
// otg function control register behind a ulpi register access port
`timescale 1ns/100ps
module uotg_otg_ctrl
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// ulpi link side
	input wire logic [7:0] ulpi_data_in,
	input wire logic ulpi_stp_in,
	output logic [7:0] ulpi_data_out,
	output logic ulpi_data_oe_out,
	output logic ulpi_dir_out,
	output logic ulpi_nxt_out,
	// bus power indicators
	input wire logic internal_vbus_valid_in,
	input wire logic fault_in,
	output logic bus_power_valid_out,
	// analog controls
	output logic supply_switch_n_out,
	output logic bus_power_charge_out,
	output logic bus_power_discharge_out,
	output logic minus_line_pulldown_en_out,
	output logic plus_line_pulldown_en_out,
	output logic cable_id_sense_en_out,
	// cable id line
	input wire logic cable_id_level_in,
	output logic cable_id_level_out
);

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_WR_ACK,
		ST_WR_DATA,
		ST_WR_STOP,
		ST_RD_ACK,
		ST_RD_TURN,
		ST_RD_DATA,
		ST_RD_END
	} uotg_state_t;

	uotg_state_t state;
	logic [5:0] cmd_addr;
	logic [7:0] wr_byte;
	logic wr_commit;
	logic [7:0] otg_value;
	logic addr_mapped;

	// access protocol sequencer
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			state <= ST_IDLE;
		else
		begin
			unique case (state)
				ST_IDLE:
				begin
					if (ulpi_data_in[7:6] == uotg_pkg::CMD_REG_WRITE)
						state <= ST_WR_ACK;
					else if (ulpi_data_in[7:6] == uotg_pkg::CMD_REG_READ)
						state <= ST_RD_ACK;
				end
				// an early stop abandons the write without touching the register
				ST_WR_ACK: state <= ulpi_stp_in ? ST_IDLE : ST_WR_DATA;
				ST_WR_DATA: state <= ulpi_stp_in ? ST_IDLE : ST_WR_STOP;
				ST_WR_STOP:
				begin
					if (ulpi_stp_in)
						state <= ST_IDLE;
				end
				ST_RD_ACK: state <= ST_RD_TURN;
				ST_RD_TURN: state <= ST_RD_DATA;
				ST_RD_DATA: state <= ST_RD_END;
				ST_RD_END: state <= ST_IDLE;
			endcase
		end
	end

	// command address, caught as the command is seen
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			cmd_addr <= 6'h00;
		else if (state == ST_IDLE && ulpi_data_in[7] == 1'b1)
			cmd_addr <= ulpi_data_in[5:0];
	end

	// write byte, caught while next is high in the data cycle
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			wr_byte <= 8'h00;
		else if (state == ST_WR_DATA)
			wr_byte <= ulpi_data_in;
	end

	// write only lands once the link has stopped, so aborts leave no trace
	assign wr_commit = (state == ST_WR_STOP) && ulpi_stp_in;

	// storage; unmapped addresses fall through its decode untouched
	uotg_reg_bank u_bank
	(
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_strobe_in(wr_commit),
		.wr_addr_in(cmd_addr),
		.wr_data_in(wr_byte),
		.value_out(otg_value)
	);

	// any of the three addresses reads the register
	assign addr_mapped = (cmd_addr == uotg_pkg::ADDR_OTG_WRITE)
		|| (cmd_addr == uotg_pkg::ADDR_OTG_SET)
		|| (cmd_addr == uotg_pkg::ADDR_OTG_CLEAR);

	// read data flop, loaded during the turnaround cycle
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			ulpi_data_out <= 8'h00;
		else if (state == ST_RD_TURN)
			ulpi_data_out <= addr_mapped ? otg_value : uotg_pkg::UNMAPPED_READ;
	end

	// bus handshakes follow the state directly
	assign ulpi_nxt_out = (state == ST_WR_ACK) || (state == ST_WR_DATA) || (state == ST_RD_ACK);
	assign ulpi_dir_out = (state == ST_RD_TURN) || (state == ST_RD_DATA);
	assign ulpi_data_oe_out = (state == ST_RD_DATA);

	// power valid source select, registered to keep the pin glitch free
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			bus_power_valid_out <= 1'b0;
		else if (otg_value[uotg_pkg::BIT_EXT_OVERCURRENT_SELECT])
			bus_power_valid_out <= fault_in;
		else
			bus_power_valid_out <= internal_vbus_valid_in;
	end

	// supply switch low enables external supply
	assign supply_switch_n_out = ~otg_value[uotg_pkg::BIT_EXTERNAL_SUPPLY_DRIVE];
	// charge resistor; srp preconditions are the link's duty
	assign bus_power_charge_out = otg_value[uotg_pkg::BIT_BUS_POWER_CHARGE];
	// discharge holds until the link clears the bit
	assign bus_power_discharge_out = otg_value[uotg_pkg::BIT_BUS_POWER_DISCHARGE];
	assign minus_line_pulldown_en_out = otg_value[uotg_pkg::BIT_MINUS_LINE_PULLDOWN];
	assign plus_line_pulldown_en_out = otg_value[uotg_pkg::BIT_PLUS_LINE_PULLDOWN];
	assign cable_id_sense_en_out = otg_value[uotg_pkg::BIT_CABLE_ID_SENSE];

	// id level only sampled while sensing, reads low when off
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			cable_id_level_out <= 1'b0;
		else if (otg_value[uotg_pkg::BIT_CABLE_ID_SENSE])
			cable_id_level_out <= cable_id_level_in;
		else
			cable_id_level_out <= 1'b0;
	end

	// checks on the register and its outputs
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	a_plain_write: assert property (wr_commit && cmd_addr == uotg_pkg::ADDR_OTG_WRITE
		|=> otg_value == $past(wr_byte))
		else $error("plain write did not store the byte");
	a_set_bits: assert property (wr_commit && cmd_addr == uotg_pkg::ADDR_OTG_SET
		|=> otg_value == ($past(otg_value) | $past(wr_byte)))
		else $error("set write did not or the byte in");
	a_clear_bits: assert property (wr_commit && cmd_addr == uotg_pkg::ADDR_OTG_CLEAR
		|=> otg_value == ($past(otg_value) & ~$past(wr_byte)))
		else $error("clear write did not clear the bits");
	a_read_value: assert property (state == ST_RD_ACK && addr_mapped
		|-> ##2 (ulpi_data_oe_out && ulpi_dir_out && ulpi_data_out == $past(otg_value, 2)))
		else $error("read did not return the register");
	a_indicator_select: assert property (1'b1
		|=> bus_power_valid_out == ($past(otg_value[7]) ? $past(fault_in)
			: $past(internal_vbus_valid_in)))
		else $error("power valid source is wrong");
	a_supply_switch: assert property (wr_commit && wr_byte[6]
		&& (cmd_addr == uotg_pkg::ADDR_OTG_WRITE || cmd_addr == uotg_pkg::ADDR_OTG_SET)
		|=> !supply_switch_n_out)
		else $error("supply switch not driven low");
	a_charge_drive: assert property ($rose(otg_value[4]) |-> bus_power_charge_out
		&& $past(wr_commit))
		else $error("charge changed without a write");
	a_discharge_hold: assert property (bus_power_discharge_out && !wr_commit
		|=> bus_power_discharge_out)
		else $error("discharge dropped without a write");
	a_reset_value: assert property (disable iff (1'b0) rst_in
		|=> minus_line_pulldown_en_out && plus_line_pulldown_en_out && !cable_id_sense_en_out)
		else $error("pull-down or id reset value wrong");
	a_id_sampler: assert property (!cable_id_sense_en_out |=> !cable_id_level_out)
		else $error("id level seen while sampler off");

	c_write: cover property (wr_commit && cmd_addr == uotg_pkg::ADDR_OTG_WRITE);
	c_set: cover property (wr_commit && cmd_addr == uotg_pkg::ADDR_OTG_SET);
	c_clear: cover property (wr_commit && cmd_addr == uotg_pkg::ADDR_OTG_CLEAR);
	c_read: cover property (state == ST_RD_DATA && addr_mapped);
	c_data_abort: cover property (state == ST_WR_DATA && ulpi_stp_in);

endmodule : uotg_otg_ctrl

// file: verilog/uotg_pkg.sv
// constants shared by the otg function control register block
package uotg_pkg;
	// register access addresses: read at any of them, write kinds by address
	localparam logic [5:0] ADDR_OTG_WRITE = 6'h0a;
	localparam logic [5:0] ADDR_OTG_SET = 6'h0b;
	localparam logic [5:0] ADDR_OTG_CLEAR = 6'h0c;
	// reset value: both data-line pull-downs connected, all else off
	localparam logic [7:0] OTG_RESET = 8'h06;
	// field positions
	localparam int BIT_EXT_OVERCURRENT_SELECT = 7;
	localparam int BIT_EXTERNAL_SUPPLY_DRIVE = 6;
	localparam int BIT_BUS_POWER_CHARGE = 4;
	localparam int BIT_BUS_POWER_DISCHARGE = 3;
	localparam int BIT_MINUS_LINE_PULLDOWN = 2;
	localparam int BIT_PLUS_LINE_PULLDOWN = 1;
	localparam int BIT_CABLE_ID_SENSE = 0;
	// transmit command codes in data[7:6], address in data[5:0]
	localparam logic [1:0] CMD_REG_WRITE = 2'h2;
	localparam logic [1:0] CMD_REG_READ = 2'h3;
	// value returned for a read of an address this block does not hold
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : uotg_pkg

// file: verilog/uotg_reg_bank.sv
// otg function control register storage with write, set and clear access
`timescale 1ns/100ps
module uotg_reg_bank
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// committed write
	input wire logic wr_strobe_in,
	input wire logic [5:0] wr_addr_in,
	input wire logic [7:0] wr_data_in,
	// stored value
	output logic [7:0] value_out
);

	// one flop per bit, each with its own reset value
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_bit
			// write, set or clear by address
			always_ff @(posedge clk_in)
			begin
				if (rst_in)
					value_out[i] <= uotg_pkg::OTG_RESET[i];
				else if (wr_strobe_in && wr_addr_in == uotg_pkg::ADDR_OTG_WRITE)
					value_out[i] <= wr_data_in[i];
				else if (wr_strobe_in && wr_addr_in == uotg_pkg::ADDR_OTG_SET)
					value_out[i] <= value_out[i] | wr_data_in[i];
				else if (wr_strobe_in && wr_addr_in == uotg_pkg::ADDR_OTG_CLEAR)
					value_out[i] <= value_out[i] & ~wr_data_in[i];
			end
		end
	endgenerate

endmodule : uotg_reg_bank

// file: test/uotg_link_model.sv
// ulpi link controller model issuing register writes and reads
`timescale 1ns/100ps
module uotg_link_model
(
	// clock
	input wire logic clk_in,
	// phy answers
	input wire logic dir_in,
	input wire logic nxt_in,
	input wire logic oe_in,
	input wire logic [7:0] rdata_in,
	// link drive
	output logic [7:0] data_out,
	output logic stp_out
);
	initial
	begin
		data_out = 8'h00;
		stp_out = 1'b0;
	end
	// bounded so a dead phy cannot hang the link; n counts edges up to next
	task automatic wait_nxt(output int n);
		n = 0;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (nxt_in !== 1'b1 && n < 8);
	endtask : wait_nxt
	// write by address; ab 1 stops in the ack cycle, 2 in the data cycle
	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] ab,
		output int lat);
		lat = 0;
		data_out <= {uotg_pkg::CMD_REG_WRITE, a};
		if (ab != 2'h1)
		begin
			wait_nxt(lat);
			data_out <= d;
			// stp beside the byte abandons the write in its data cycle
			if (ab == 2'h2)
				stp_out <= 1'b1;
		end
		@(posedge clk_in);
		// stp in the ack cycle aborts, after the data cycle commits
		stp_out <= (ab != 2'h2);
		data_out <= 8'h00;
		@(posedge clk_in);
		stp_out <= 1'b0;
		@(posedge clk_in);
	endtask : wr
	task automatic rd(input logic [5:0] a, output logic [7:0] d, output int lat);
		data_out <= {uotg_pkg::CMD_REG_READ, a};
		wait_nxt(lat);
		// phy owns the bus: show a changed pattern, not the last byte
		data_out <= ~{uotg_pkg::CMD_REG_READ, a};
		@(posedge clk_in);
		@(posedge clk_in);
		d = (oe_in === 1'b1 && dir_in === 1'b1) ? rdata_in : 8'hxx;
		data_out <= 8'h00;
		@(posedge clk_in);
	endtask : rd
endmodule : uotg_link_model

// file: test/tb_top.sv
// self-checking bench for the otg function control register
`timescale 1ns/100ps
module tb_top;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic iv = 1'b0;
	logic flt = 1'b0;
	logic idl = 1'b0;
	logic [7:0] ld, dd, rv;
	logic stp, oe, dir, nxt, pv, swn, chg, dis, mpd, ppd, ids, ido;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	always #2 clk_in = ~clk_in;
	uotg_otg_ctrl u_dut (.clk_in(clk_in), .rst_in(rst_in), .ulpi_data_in(ld),
		.ulpi_stp_in(stp), .ulpi_data_out(dd), .ulpi_data_oe_out(oe), .ulpi_dir_out(dir),
		.ulpi_nxt_out(nxt), .internal_vbus_valid_in(iv), .fault_in(flt),
		.bus_power_valid_out(pv), .supply_switch_n_out(swn), .bus_power_charge_out(chg),
		.bus_power_discharge_out(dis), .minus_line_pulldown_en_out(mpd),
		.plus_line_pulldown_en_out(ppd), .cable_id_sense_en_out(ids),
		.cable_id_level_in(idl), .cable_id_level_out(ido));
	uotg_link_model u_link (.clk_in(clk_in), .dir_in(dir), .nxt_in(nxt), .oe_in(oe),
		.rdata_in(dd), .data_out(ld), .stp_out(stp));
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	// hang guard far above the hundred or so cycles needed
	always @(posedge clk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			n_errors++;
			print_verdict();
		end
	end
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8
	// pins against a register image; bit 7 only steers a mux
	task automatic chk_pins(input logic [7:0] e);
		@(negedge clk_in);
		chk8({1'b0, ~swn, 1'b0, chg, dis, mpd, ppd, ids}, e & 8'h5f);
		@(posedge clk_in);
	endtask : chk_pins
	task automatic chk_rd(input logic [5:0] a, input logic [7:0] e);
		int lat;
		u_link.rd(a, rv, lat);
		chk8(rv, e);
		// next comes one cycle after the command edge, seen two edges on
		chk8(8'(lat), 8'h02);
		// read end hands the bus back: every handshake low
		chk8({5'h00, nxt, dir, oe}, 8'h00);
	endtask : chk_rd
	task automatic chk_wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] ab);
		int lat;
		u_link.wr(a, d, ab, lat);
		// an ack-cycle stop never waits for next, so no latency to judge
		if (ab != 2'h1)
			chk8(8'(lat), 8'h02);
		chk8({5'h00, nxt, dir, oe}, 8'h00);
	endtask : chk_wr
	task automatic t_reset();
		chk_pins(8'h06);
		chk_rd(uotg_pkg::ADDR_OTG_WRITE, 8'h06);
	endtask : t_reset
	task automatic t_wsc();
		// external supply on and discharge started, charge kept off meanwhile
		chk_wr(uotg_pkg::ADDR_OTG_WRITE, 8'h4a, 2'h0);
		chk_pins(8'h4a);
		chk_wr(uotg_pkg::ADDR_OTG_SET, 8'h24, 2'h0);
		chk_rd(uotg_pkg::ADDR_OTG_SET, 8'h6e);
		// session end seen rising, so the link stops discharging
		chk_wr(uotg_pkg::ADDR_OTG_CLEAR, 8'h08, 2'h0);
		chk_pins(8'h66);
		// bus discharged and se0 held long enough: charging may start
		chk_wr(uotg_pkg::ADDR_OTG_SET, 8'h10, 2'h0);
		chk_pins(8'h76);
		chk_wr(uotg_pkg::ADDR_OTG_CLEAR, 8'h58, 2'h0);
		chk_rd(uotg_pkg::ADDR_OTG_CLEAR, 8'h26);
		chk_pins(8'h26);
		// stops in the ack and in the data cycle leave the register alone
		chk_wr(uotg_pkg::ADDR_OTG_WRITE, 8'hff, 2'h1);
		chk_wr(uotg_pkg::ADDR_OTG_WRITE, 8'hff, 2'h2);
		chk_wr(6'h0d, 8'hff, 2'h0);
		chk_rd(6'h0d, uotg_pkg::UNMAPPED_READ);
		chk_rd(uotg_pkg::ADDR_OTG_WRITE, 8'h26);
	endtask : t_wsc
	task automatic t_power();
		iv <= 1'b1;
		repeat (2) @(posedge clk_in);
		chk8({7'h00, pv}, 8'h01);
		chk_wr(uotg_pkg::ADDR_OTG_SET, 8'h80, 2'h0);
		@(posedge clk_in);
		chk8({7'h00, pv}, 8'h00);
		flt <= 1'b1;
		iv <= 1'b0;
		repeat (2) @(posedge clk_in);
		chk8({7'h00, pv}, 8'h01);
	endtask : t_power
	task automatic t_id();
		idl <= 1'b1;
		chk_wr(uotg_pkg::ADDR_OTG_SET, 8'h01, 2'h0);
		chk_pins(8'ha7);
		chk8({7'h00, ido}, 8'h01);
		idl <= 1'b0;
		repeat (2) @(posedge clk_in);
		chk8({7'h00, ido}, 8'h00);
		chk_wr(uotg_pkg::ADDR_OTG_CLEAR, 8'h01, 2'h0);
		idl <= 1'b1;
		repeat (2) @(posedge clk_in);
		chk8({7'h00, ido}, 8'h00);
	endtask : t_id
	initial
	begin
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		t_reset();
		t_wsc();
		t_power();
		t_id();
		// second reset in mid-run must restore defaults
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		t_reset();
		print_verdict();
	end
endmodule : tb_top
